// *** rtl/ssf_core.sv ***
// Serial status flags, interrupt gating, rate select and data port.
// Assumes a plain synchronous register port and synchronous pin inputs.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_core (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input wire ssf_pkg::ssf_bus_s bus,
   output logic [7:0] rdata,
   // Clock generator base enable
   input wire logic clockgen_base_clock,
   // Serial pins
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic miso_i,
   input wire logic select_n_i,
   output ssf_pkg::ssf_pins_s pins,
   output logic select_pin_gpio,
   // Interrupt requests
   output logic irq_rx,
   output logic irq_tx,
   output logic irq_err
);
   import ssf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0] ctrl_q;
   logic rx_full_flag_q, overrun_flag_q, select_fault_flag_q, tx_empty_flag_q;
   logic error_irq_enable_q, select_fault_detect_enable_q;
   logic [1:0] rate_q;
   logic [7:0] tx_q, rx_q, shift_q;
   logic [3:0] bits_q;
   logic sclk_q, sel_prev_q, sclk_prev_q;
   logic tx_pending_q;
   logic seen_rxf_q, seen_ovr_q, seen_select_fault_flag_q;
   ssf_state_e state_q;

   logic enabled, master, slave_sel;
   logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
   logic byte_done, handoff, half_tick, fault_set;
   logic [7:0] stat_val;

   assign wr_ctrl = bus.wr && bus.addr == `SSF_ADDR_CTRL;
   assign wr_stat = bus.wr && bus.addr == `SSF_ADDR_STAT;
   assign wr_data = bus.wr && bus.addr == `SSF_ADDR_DATA;
   assign rd_stat = bus.rd && bus.addr == `SSF_ADDR_STAT;
   assign rd_data = bus.rd && bus.addr == `SSF_ADDR_DATA;

   assign enabled = ctrl_q[`SSF_CR_EN];
   assign master = enabled && ctrl_q[`SSF_CR_MSTR];
   assign slave_sel = enabled && !ctrl_q[`SSF_CR_MSTR] && !select_n_i;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `SSF_CR_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= bus.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         error_irq_enable_q <= 1'b0;
      end else if (wr_stat) begin
         error_irq_enable_q <= bus.wdata[`SSF_SR_ERROR_IRQ_ENABLE];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         select_fault_detect_enable_q <= 1'b0;
      end else if (wr_stat) begin
         select_fault_detect_enable_q <= bus.wdata[`SSF_SR_SELECT_FAULT_DETECT_ENABLE];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rate_q <= 2'h0;
      end else if (wr_stat) begin
         rate_q <= bus.wdata[`SSF_SR_RATE_HI:`SSF_SR_RATE_LO];
      end
   end

   // Transmit holding register; read side never sees it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_q <= 8'h00;
      end else if (wr_data) begin
         tx_q <= bus.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift engine, kept minimal (master samples on second edge, slave on the sclk_i rise)

   ssf_rate_div u_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(master && state_q == ST_SHIFT),
      .base_tick(clockgen_base_clock),
      .rate_sel(rate_q),
      .half_tick(half_tick)
   );

   logic slave_edge;
   assign slave_edge = slave_sel && sclk_i && !sclk_prev_q;

   // Handoff happens when idle and a byte waits; slave only while selected
   // Limitation: a slave shifts nothing until software has written a byte
   assign handoff = state_q == ST_IDLE && tx_pending_q && (master || slave_sel);
   assign byte_done = state_q == ST_DONE;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         shift_q <= 8'h00;
         bits_q <= 4'h0;
         sclk_q <= 1'b0;
      end else if (!enabled) begin
         state_q <= ST_IDLE;
         sclk_q <= 1'b0;
         bits_q <= 4'h0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               bits_q <= 4'h0;
               sclk_q <= 1'b0;
               if (handoff) begin
                  shift_q <= tx_q;
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (master && half_tick) begin
                  sclk_q <= !sclk_q;
                  if (sclk_q) begin
                     shift_q <= {shift_q[6:0], miso_i};
                     bits_q <= bits_q + 4'h1;
                     if (bits_q == `SSF_BITS - 4'h1) begin
                        state_q <= ST_DONE;
                     end
                  end
               end else if (!master && slave_edge) begin
                  shift_q <= {shift_q[6:0], mosi_i};
                  bits_q <= bits_q + 4'h1;
                  if (bits_q == `SSF_BITS - 4'h1) begin
                     state_q <= ST_DONE;
                  end
               end else if (!master && !slave_sel) begin
                  // Deselected slave drops the partial byte
                  state_q <= ST_IDLE;
               end
            end
            ST_DONE: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev_q <= 1'b0;
         sel_prev_q <= 1'b1;
      end else begin
         sclk_prev_q <= sclk_i;
         sel_prev_q <= select_n_i;
      end
   end

   // Held byte survives overrun; newest byte discarded
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_q <= 8'h00;
      end else if (byte_done && !rx_full_flag_q) begin
         rx_q <= shift_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_pending_q <= 1'b0;
      end else if (wr_data) begin
         tx_pending_q <= 1'b1;
      end else if (handoff) begin
         tx_pending_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags; a set in the clearing cycle wins

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seen_rxf_q <= 1'b0;
      end else if (rd_stat) begin
         seen_rxf_q <= rx_full_flag_q;
      end else if (rd_data) begin
         seen_rxf_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seen_ovr_q <= 1'b0;
      end else if (rd_stat) begin
         seen_ovr_q <= overrun_flag_q;
      end else if (rd_data) begin
         seen_ovr_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seen_select_fault_flag_q <= 1'b0;
      end else if (rd_stat) begin
         seen_select_fault_flag_q <= select_fault_flag_q;
      end else if (wr_ctrl) begin
         seen_select_fault_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_full_flag_q <= 1'b0;
      end else if (byte_done && !rx_full_flag_q) begin
         rx_full_flag_q <= 1'b1;
      end else if (rd_data && seen_rxf_q) begin
         rx_full_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         overrun_flag_q <= 1'b0;
      end else if (byte_done && rx_full_flag_q) begin
         overrun_flag_q <= 1'b1;
      end else if (rd_data && seen_ovr_q) begin
         overrun_flag_q <= 1'b0;
      end
   end

   // Detect enable only gates setting, never clears
   assign fault_set = enabled && select_fault_detect_enable_q && (
      (master && !select_n_i) ||
      (!ctrl_q[`SSF_CR_MSTR] && state_q == ST_SHIFT && select_n_i && !sel_prev_q));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         select_fault_flag_q <= 1'b0;
      end else if (fault_set) begin
         select_fault_flag_q <= 1'b1;
      end else if (wr_ctrl && seen_select_fault_flag_q) begin
         select_fault_flag_q <= 1'b0;
      end
   end

   // Handoff wins over a same-cycle write, which software must not issue
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_empty_flag_q <= 1'b1;
      end else if (handoff) begin
         tx_empty_flag_q <= 1'b1;
      end else if (wr_data) begin
         tx_empty_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe

   always_comb begin
      stat_val = 8'h00;
      stat_val[`SSF_SR_RXF] = rx_full_flag_q;
      stat_val[`SSF_SR_ERROR_IRQ_ENABLE] = error_irq_enable_q;
      stat_val[`SSF_SR_OVR] = overrun_flag_q;
      stat_val[`SSF_SR_SELECT_FAULT_FLAG] = select_fault_flag_q;
      stat_val[`SSF_SR_TXE] = tx_empty_flag_q;
      stat_val[`SSF_SR_SELECT_FAULT_DETECT_ENABLE] = select_fault_detect_enable_q;
      stat_val[`SSF_SR_RATE_HI:`SSF_SR_RATE_LO] = rate_q;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            `SSF_ADDR_CTRL: rdata <= ctrl_q;
            `SSF_ADDR_STAT: rdata <= stat_val;
            `SSF_ADDR_DATA: rdata <= rx_q;
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins and interrupts

   always_comb begin
      pins.sclk_o = sclk_q;
      pins.sclk_oe = master;
      pins.mosi_o = shift_q[7];
      pins.mosi_oe = master;
      pins.miso_o = shift_q[7];
      pins.miso_oe = slave_sel;
   end

   assign select_pin_gpio = !enabled || (master && !select_fault_detect_enable_q);

   assign irq_rx = rx_full_flag_q && ctrl_q[`SSF_CR_RXIE];
   assign irq_tx = tx_empty_flag_q && ctrl_q[`SSF_CR_TXIE];
   assign irq_err = error_irq_enable_q && (overrun_flag_q || select_fault_flag_q);

endmodule : ssf_core

// *** rtl/ssf_params.svh ***
// Constants for the serial status, flag and data-port block.
// Assumes inclusion by the package, the design files, the checker and the bench.
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH

// Register addresses on the plain port
`define SSF_ADDR_CTRL 2'h0
`define SSF_ADDR_STAT 2'h1
`define SSF_ADDR_DATA 2'h2

// Control register fields
`define SSF_CR_RXIE 7
`define SSF_CR_MSTR 5
`define SSF_CR_TXIE 1
`define SSF_CR_EN 0
`define SSF_CR_RESET 8'h20

// Status and control register fields
`define SSF_SR_RXF 7
`define SSF_SR_ERROR_IRQ_ENABLE 6
`define SSF_SR_OVR 5
`define SSF_SR_SELECT_FAULT_FLAG 4
`define SSF_SR_TXE 3
`define SSF_SR_SELECT_FAULT_DETECT_ENABLE 2
`define SSF_SR_RATE_HI 1
`define SSF_SR_RATE_LO 0

// Divisors and the number of bits per byte
`define SSF_BD0 8'h02
`define SSF_BD1 8'h08
`define SSF_BD2 8'h20
`define SSF_BD3 8'h80
`define SSF_BITS 4'h8

`endif

// *** rtl/ssf_pkg.sv ***
// Types for the serial status, flag and data-port block.
// Assumes the params header sits beside it.
`include "ssf_params.svh"

package ssf_pkg;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ssf_bus_s;

   typedef struct packed {
      logic sclk_o;
      logic sclk_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
   } ssf_pins_s;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} ssf_state_e;

endpackage : ssf_pkg

// *** rtl/ssf_rate_div.sv ***
// Serial clock divider: one enable pulse per serial half period.
// Assumes clockgen_base_clock arrives as a one-cycle enable on clk_sys.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_rate_div (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic base_tick,
   input wire logic [1:0] rate_sel,
   // Half-period pulse
   output logic half_tick
);
   logic [7:0] cnt_q;
   logic [7:0] rate_divisor;

   always_comb begin
      unique case (rate_sel)
         2'h0: rate_divisor = `SSF_BD0;
         2'h1: rate_divisor = `SSF_BD1;
         2'h2: rate_divisor = `SSF_BD2;
         2'h3: rate_divisor = `SSF_BD3;
      endcase
   end

   // Half period lasts rate_divisor base ticks, so full period is 2 x divisor
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
      end else if (!run) begin
         cnt_q <= 8'h00;
      end else if (base_tick) begin
         if (cnt_q == rate_divisor - 8'h01) begin
            cnt_q <= 8'h00;
         end else begin
            cnt_q <= cnt_q + 8'h01;
         end
      end
   end

   assign half_tick = run && base_tick && (cnt_q == rate_divisor - 8'h01);

endmodule : ssf_rate_div

// *** testbench/ssf_core_assertions.sv ***
// Port checker for the serial flag block.
// Assumes the package and params header are compiled first.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_core_assertions (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Watched ports
   input wire ssf_pkg::ssf_bus_s bus,
   input wire logic [7:0] rdata,
   input wire ssf_pkg::ssf_pins_s pins,
   input wire logic select_pin_gpio,
   input wire logic irq_rx,
   input wire logic irq_tx,
   input wire logic irq_err
);
   import ssf_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   property p_rdata_idle;
      !bus.rd |=> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read");
   property p_tx_wr;
      bus.wr && bus.addr == `SSF_ADDR_DATA |=> !irq_tx;
   endproperty
   a_tx_wr: assert property (p_tx_wr)
      else $error("transmit request kept after data write");
   property p_tx_rise;
      $rose(irq_tx) |-> !($past(bus.wr) && $past(bus.addr) == `SSF_ADDR_DATA);
   endproperty
   a_tx_rise: assert property (p_tx_rise)
      else $error("transmit request rose on data write");
   property p_rx_fall;
      $fell(irq_rx) |-> $past(bus.rd) && $past(bus.addr) == `SSF_ADDR_DATA
         || $past(bus.wr) && $past(bus.addr) == `SSF_ADDR_CTRL;
   endproperty
   a_rx_fall: assert property (p_rx_fall)
      else $error("receive request fell without data read");
   property p_err_fall;
      $fell(irq_err) |-> $past(bus.rd) || $past(bus.wr);
   endproperty
   a_err_fall: assert property (p_err_fall)
      else $error("error request fell without access");
   property p_sclk_high;
      $rose(pins.sclk_o) |=> pins.sclk_o;
   endproperty
   a_sclk_high: assert property (p_sclk_high)
      else $error("serial clock high under two cycles");
   property p_gpio;
      select_pin_gpio |-> !pins.miso_oe;
   endproperty
   a_gpio: assert property (p_gpio)
      else $error("select pin freed while slave drives");
   property p_oe_pair;
      pins.sclk_oe |-> pins.mosi_oe && !pins.miso_oe;
   endproperty
   a_oe_pair: assert property (p_oe_pair)
      else $error("master pin enables inconsistent");
endmodule : ssf_core_assertions

bind ssf_core ssf_core_assertions ssf_core_assertions_i (.clk_sys(clk_sys), .rst_n(rst_n),
   .bus(bus), .rdata(rdata), .pins(pins), .select_pin_gpio(select_pin_gpio),
   .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_err(irq_err));

// *** testbench/ssf_remote_slave.sv ***
// Remote serial slave answering the master byte for byte.
// Assumes the serial clock idles low; mosi is taken on its rise.
`timescale 1ns/1ps

module ssf_remote_slave (
   // Serial side
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   // Bench side
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte
);
   logic [7:0] out_q;
   logic [7:0] in_q;
   int n;
   initial begin
      out_q = 8'h00;
      in_q = 8'h00;
      rx_byte = 8'h00;
      n = 0;
   end
   // Master moves mosi on the fall, so the rise is the stable sampling point
   always @(posedge sclk) begin
      if (n == 0) out_q <= tx_byte;
      else out_q <= out_q << 1;
      in_q <= {in_q[6:0], mosi};
      if (n == 7) rx_byte <= {in_q[6:0], mosi};
      n <= (n + 1) % 8;
   end
   assign miso = out_q[7];
endmodule : ssf_remote_slave

// *** testbench/ssf_core_bench.sv ***
// Self-checking bench for the serial flag block, master and slave side.
// Assumes the remote slave model and checker are compiled first.
`timescale 1ns/1ps
`include "ssf_params.svh"

module ssf_core_bench;
   import ssf_pkg::*;
   logic clk_sys, rst_n, select_n_i, miso_i, select_pin_gpio, irq_rx, irq_tx, irq_err;
   logic sclk_b, mosi_b;
   ssf_bus_s bus;
   ssf_pins_s pins;
   logic [7:0] rdata, v, b, tx_byte, rx_byte;
   int n_fail, compares, t;
   logic [7:0] exp_q[$];

   ssf_core ssf_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .clockgen_base_clock(1'b1), .sclk_i(sclk_b), .mosi_i(mosi_b), .miso_i(miso_i),
      .select_n_i(select_n_i), .pins(pins), .select_pin_gpio(select_pin_gpio),
      .irq_rx(irq_rx), .irq_tx(irq_tx), .irq_err(irq_err));
   ssf_remote_slave ssf_remote_slave_i (.sclk(pins.sclk_o), .mosi(pins.mosi_o),
      .miso(miso_i), .tx_byte(tx_byte), .rx_byte(rx_byte));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask : wr
   // Read data stands one cycle only, so grab it mid-cycle
   task automatic rd(input logic [1:0] a);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      @(negedge clk_sys);
      v = rdata;
   endtask : rd
   task automatic wait_irq(input logic k);
      for (int i = 0; i < 3000 && (k ? irq_err : irq_rx) !== 1'b1; i++) @(negedge clk_sys);
   endtask : wait_irq
   task automatic send(input logic [7:0] s);
      b = $urandom;
      tx_byte <= s;
      exp_q.push_back(s);
      wr(`SSF_ADDR_DATA, b);
   endtask : send
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      $display("Error watchdog expired");
      report_and_stop();
   end
   initial begin
      void'($urandom(32'h88c6e8fd));
      rst_n = 1'b0;
      bus = '0;
      select_n_i = 1'b1;
      tx_byte = 8'h00;
      sclk_b = 1'b0;
      mosi_b = 1'b0;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd(`SSF_ADDR_CTRL);
      chk("ctrl", v, `SSF_CR_RESET);
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'h08);
      rd(2'h3);
      chk("unmapped", v, 8'h00);
      chk("gpio", select_pin_gpio, 8'h01);
      $display("reset test done");
      for (int r = 0; r < 4; r++) begin
         wr(`SSF_ADDR_STAT, 8'(r));
         wr(`SSF_ADDR_CTRL, 8'ha3);
         @(negedge clk_sys);
         chk("irq_tx", irq_tx, 8'h01);
         send($urandom);
         @(negedge clk_sys);
         chk("irq_tx", irq_tx, 8'h00);
         t = 0;
         while (pins.sclk_o !== 1'b1 && t < 300) begin
            @(negedge clk_sys);
            t++;
         end
         t = 0;
         while (pins.sclk_o === 1'b1 && t < 300) begin
            @(negedge clk_sys);
            t++;
         end
         chk("sclk high", t[7:0], 8'h02 << (2 * r));
         wait_irq(1'b0);
         chk("irq_rx", irq_rx, 8'h01);
         rd(`SSF_ADDR_STAT);
         chk("status", v, 8'h88 | 8'(r));
         rd(`SSF_ADDR_DATA);
         chk("rx data", v, exp_q.pop_front());
         chk("far byte", rx_byte, b);
         rd(`SSF_ADDR_STAT);
         chk("status", v, 8'h08 | 8'(r));
         chk("irq_rx", irq_rx, 8'h00);
      end
      $display("rate test done");
      wr(`SSF_ADDR_STAT, 8'h40);
      send($urandom);
      wait_irq(1'b0);
      rd(`SSF_ADDR_STAT);
      tx_byte <= $urandom;
      wr(`SSF_ADDR_DATA, b);
      wait_irq(1'b1);
      chk("irq_err", irq_err, 8'h01);
      rd(`SSF_ADDR_DATA);
      chk("rx data", v, exp_q.pop_front());
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'h68);
      rd(`SSF_ADDR_DATA);
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'h48);
      chk("irq_err", irq_err, 8'h00);
      $display("overrun test done");
      wr(`SSF_ADDR_STAT, 8'h44);
      @(negedge clk_sys);
      chk("gpio", select_pin_gpio, 8'h00);
      @(posedge clk_sys);
      select_n_i <= 1'b0;
      wait_irq(1'b1);
      @(posedge clk_sys);
      select_n_i <= 1'b1;
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'h5c);
      wr(`SSF_ADDR_STAT, 8'h40);
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'h58);
      chk("gpio", select_pin_gpio, 8'h01);
      wr(`SSF_ADDR_CTRL, 8'ha3);
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'h48);
      chk("irq_err", irq_err, 8'h00);
      @(posedge clk_sys);
      select_n_i <= 1'b0;
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'h48);
      @(posedge clk_sys);
      select_n_i <= 1'b1;
      $display("fault test done");
      wr(`SSF_ADDR_STAT, 8'h44);
      wr(`SSF_ADDR_CTRL, 8'h81);
      @(posedge clk_sys);
      select_n_i <= 1'b0;
      @(negedge clk_sys);
      chk("miso oe", pins.miso_oe, 8'h01);
      chk("gpio", select_pin_gpio, 8'h00);
      send($urandom);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_sys);
         mosi_b <= exp_q[0][i];
         @(posedge clk_sys);
         sclk_b <= 1'b1;
         @(posedge clk_sys);
         sclk_b <= 1'b0;
      end
      wait_irq(1'b0);
      chk("irq_rx", irq_rx, 8'h01);
      rd(`SSF_ADDR_DATA);
      chk("rx data", v, exp_q.pop_front());
      chk("irq_rx", irq_rx, 8'h01);
      wr(`SSF_ADDR_DATA, b);
      @(posedge clk_sys);
      select_n_i <= 1'b1;
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'hdc);
      chk("irq_err", irq_err, 8'h01);
      wr(`SSF_ADDR_CTRL, 8'h81);
      wr(`SSF_ADDR_STAT, 8'h40);
      @(posedge clk_sys);
      select_n_i <= 1'b0;
      wr(`SSF_ADDR_DATA, b);
      @(posedge clk_sys);
      select_n_i <= 1'b1;
      rd(`SSF_ADDR_STAT);
      chk("status", v, 8'hc8);
      chk("irq_err", irq_err, 8'h00);
      $display("slave test done");
      report_and_stop();
   end
endmodule : ssf_core_bench
